// File: pkg/rbm_pkg.sv
// ****************************************************
// Busy indicator and mode control constants
// ****************************************************
package rbm_pkg;
    // Core clock rate in MHz
    localparam int CLK_MHZ = 200;
    // Least wait after the busy rising edge before a mode change
    localparam int MODE_SETTLE_US = 2000;
    // Longest wait before a deferred sleep request is honoured
    localparam int SLEEP_ENTRY_US = 1000;
    // Cycle counts derived from the times above
    localparam int SETTLE_CYC = (MODE_SETTLE_US * CLK_MHZ + 0) / 1;
    localparam int SLEEP_CYC = (SLEEP_ENTRY_US * CLK_MHZ) / 1;
    // Width of the idle-time counter
    localparam int HCNT_W = 19;
    // Transmit buffer capacity in bytes and its counter width
    localparam int TXBUF_BYTES = 1000;
    localparam int TXCNT_W = 10;
    localparam logic [TXCNT_W-1:0] TXCNT_FULL = 10'h3e8;
    // Module address that means broadcast and monitor
    localparam logic [15:0] ADDR_ALL_ONES = 16'hffff;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_TXCNT = 8'h0c;
    // Control register bit positions
    localparam int CTRL_CFG_DONE = 0;
    localparam int CTRL_RX_PEND = 1;
    // Status register bit positions
    localparam int STAT_AUX = 0;
    localparam int STAT_MODE = 1;
    localparam int STAT_PINS = 3;
    localparam int STAT_BCAST = 5;
    localparam int STAT_INIT = 6;
    // Operating modes, coded {mode_select_high, mode_select_low}
    typedef enum logic [1:0] {
        RBM_MODE_NORMAL = 2'h0,
        RBM_MODE_WOR = 2'h1,
        RBM_MODE_CONFIG = 2'h2,
        RBM_MODE_SLEEP = 2'h3
    } rbm_mode_type;
    // Top level control states, one-hot
    typedef enum logic [2:0] {
        RBM_INIT = 3'h1,
        RBM_RUN = 3'h2,
        RBM_SLEEP = 3'h4
    } rbm_state_type;
endpackage

// File: src/rbm_sync.sv
`timescale 1ns/10ps
// ****************************************************
// Two flip-flop synchroniser for the mode pins
// ****************************************************
module rbm_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] pin_async,
    output logic [1:0] pin_sync
);
    // First and second stage of the chain
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } rbm_sync_type;

    rbm_sync_type q, d;

    // Next stage values; only the second stage reads the first
    always_comb begin
        d = q;
        d.s1 = pin_async;
        d.s2 = q.s1;
    end

    // Registers clear to mode 0 under reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_sync = q.s2;
endmodule

// File: src/rbm_core.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// (RULE_01) All-ones address makes transmissions broadcast
// (RULE_02) All-ones address receives every packet
// (RULE_03) Busy low through power-on self-test
// (RULE_04) After init, raise busy, follow pins
// (RULE_05) Host waits for busy rising edge
// (RULE_06) Busy low for tx, rx, init
// (RULE_07) Busy low around received serial output
// (RULE_08) 1000-byte transmit buffer never overflows
// (RULE_09) Non-empty transmit buffer keeps busy low
// (RULE_10) Busy may rise before last packet
// (RULE_11) Config busy only at reset, wake
// (RULE_12) Busy is the OR of conditions
// (RULE_13) Pins ignored while busy is low; the code still samples them once, at the end of initialisation
// (RULE_14) Mode applies no earlier than 2ms
// (RULE_15) Steady idle means immediate mode change
// (RULE_16) Leaving sleep reloads parameters, busy low
// (RULE_17) Pins 00 select normal transparent mode
// (RULE_18) Pins 01 select wake-on-air mode
// (RULE_19) Pins 10 select register configuration mode
// (RULE_20) Pins 11 select sleep
// (RULE_21) Host waits 2ms idle before switching
// (RULE_22) Deferred sleep entered within 1ms
// (RULE_23) Mode pins synchronised before use
module rbm_core #(
    parameter int SETTLE_CYCLES = rbm_pkg::SETTLE_CYC,
    parameter int SLEEP_CYCLES = rbm_pkg::SLEEP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic tx_push,
    output logic tx_ready,
    input wire logic tx_pop,
    output logic tx_avail,
    input wire logic rx_out_active,
    input wire logic pkt_valid,
    input wire logic [15:0] pkt_dst,
    output logic pkt_accept,
    output logic tx_broadcast,
    output logic aux,
    output logic [1:0] mode_out,
    output logic radio_en,
    output logic uart_en,
    output logic reg_access_en,
    output logic wor_en,
    output logic sleep_en
);
    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        rbm_pkg::rbm_state_type st;          // Control state
        rbm_pkg::rbm_mode_type mode;         // Mode in force
        logic [1:0] pins;                    // Pins seen while idle
        logic [15:0] addr;                   // Module address
        logic rxp;                           // Received data waiting
        logic [rbm_pkg::TXCNT_W-1:0] cnt;    // Buffer fill
        logic [rbm_pkg::HCNT_W-1:0] hcnt;    // Cycles busy stayed high
        logic aux;                           // Busy indicator, high idle
        logic [31:0] prdata;                 // Read data latch
    } rbm_core_type;

    rbm_core_type q, d;
    logic [1:0] pins_s;    // Synchronised mode pins
    logic busy;            // Any busy condition holds
    logic acc;             // APB access phase
    logic wr;              // APB write in access phase
    logic push_ok;         // Byte accepted into buffer
    logic pop_ok;          // Byte drained to the radio
    logic [rbm_pkg::HCNT_W-1:0] need;    // Idle time a change waits
    logic change_ok;       // Mode change may be applied now

    // ****************************************************
    // Helpers
    // ****************************************************
    // Whether an offset is one of the four registers
    function automatic logic rbm_mapped(input logic [7:0] a);
        return (a == rbm_pkg::OFF_CTRL) || (a == rbm_pkg::OFF_ADDR) ||
               (a == rbm_pkg::OFF_STAT) || (a == rbm_pkg::OFF_TXCNT);
    endfunction

    // Read word for an offset; unmapped and reserved bits read zero
    function automatic logic [31:0] rbm_rd(input logic [7:0] a,
                                           input rbm_core_type s);
        logic [31:0] w;
        w = '0;
        unique case (a)
            rbm_pkg::OFF_CTRL: begin
                w[rbm_pkg::CTRL_RX_PEND] = s.rxp;
            end
            rbm_pkg::OFF_ADDR: begin
                w[15:0] = s.addr;
            end
            rbm_pkg::OFF_STAT: begin
                w[rbm_pkg::STAT_AUX] = s.aux;
                w[rbm_pkg::STAT_MODE +: 2] = s.mode;
                w[rbm_pkg::STAT_PINS +: 2] = s.pins;
                w[rbm_pkg::STAT_BCAST] = (s.addr == rbm_pkg::ADDR_ALL_ONES);
                w[rbm_pkg::STAT_INIT] = (s.st == rbm_pkg::RBM_INIT);
            end
            rbm_pkg::OFF_TXCNT: begin
                w[rbm_pkg::TXCNT_W-1:0] = s.cnt;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // Pins go through two flops before any decision reads them
    rbm_sync u_sync (    // see RULE_23
        .pclk(pclk),
        .presetn(presetn),
        .pin_async({mode_select_high, mode_select_low}),
        .pin_sync(pins_s)
    );

    // ****************************************************
    // Next state
    // ****************************************************
    // Busy terms, buffer, idle timer, mode machine and registers
    always_comb begin
        d = q;
        acc = psel && penable;
        wr = acc && pwrite;
        // Any single condition pulls busy low; high needs all clear
        busy = (q.st == rbm_pkg::RBM_INIT) || (q.cnt != '0) ||
               q.rxp || rx_out_active;    // see RULE_06
        d.aux = !busy;    // see RULE_12
        // Buffer accounting; a push at full is refused
        push_ok = tx_push && (q.cnt != rbm_pkg::TXCNT_FULL);    // see RULE_08
        // Busy rises once the last byte leaves the buffer, even
        // though that packet may still be on the air
        pop_ok = tx_pop && (q.cnt != '0);    // see RULE_10
        if (push_ok && !pop_ok) begin
            d.cnt = q.cnt + 10'h001;
        end else if (pop_ok && !push_ok) begin
            d.cnt = q.cnt - 10'h001;    // see RULE_09
        end
        // Pins are looked at while the indicator is high, and once more when initialisation ends
        if (q.aux) begin
            d.pins = pins_s;    // see RULE_13
        end
        // Time spent idle, saturating at the longer wait
        if (!q.aux) begin
            d.hcnt = '0;
        end else if (q.hcnt < SETTLE_CYCLES[rbm_pkg::HCNT_W-1:0]) begin
            d.hcnt = q.hcnt + 19'h00001;
        end
        // Sleep waits the shorter time, other modes the longer one
        if (q.pins == rbm_pkg::RBM_MODE_SLEEP) begin
            need = SLEEP_CYCLES[rbm_pkg::HCNT_W-1:0];    // see RULE_22
        end else begin
            need = SETTLE_CYCLES[rbm_pkg::HCNT_W-1:0];    // see RULE_14
        end
        // A saturated timer lets a change through at once
        change_ok = q.aux && !busy && (q.hcnt >= need);    // see RULE_15
        // Mode machine
        unique case (q.st)
            rbm_pkg::RBM_INIT: begin
                // Stored parameters applied; follow the pins from now
                if (wr && (paddr == rbm_pkg::OFF_CTRL) &&
                    pwdata[rbm_pkg::CTRL_CFG_DONE]) begin
                    d.st = rbm_pkg::RBM_RUN;    // see RULE_04
                    d.pins = pins_s;
                    d.mode = rbm_pkg::rbm_mode_type'(pins_s);
                    if (pins_s == rbm_pkg::RBM_MODE_SLEEP) begin
                        d.st = rbm_pkg::RBM_SLEEP;
                    end
                end
            end
            rbm_pkg::RBM_RUN: begin
                // Pending change applies only after idle time
                if ((q.pins != q.mode) && change_ok) begin
                    d.mode = rbm_pkg::rbm_mode_type'(q.pins);
                    if (q.pins == rbm_pkg::RBM_MODE_SLEEP) begin
                        d.st = rbm_pkg::RBM_SLEEP;    // see RULE_20
                    end
                end
            end
            rbm_pkg::RBM_SLEEP: begin
                // Waking reloads parameters with busy held low
                if (q.aux && (q.pins != rbm_pkg::RBM_MODE_SLEEP)) begin
                    d.st = rbm_pkg::RBM_INIT;    // see RULE_16, see RULE_11
                end
            end
            default: begin
                // Illegal code: restart as after power-on
                d.st = rbm_pkg::RBM_INIT;
            end
        endcase
        // Register writes at the access phase
        if (wr && (paddr == rbm_pkg::OFF_CTRL)) begin
            d.rxp = pwdata[rbm_pkg::CTRL_RX_PEND];    // see RULE_07
        end
        if (wr && (paddr == rbm_pkg::OFF_ADDR)) begin
            d.addr = pwdata[15:0];
        end
        // Read data captured in the setup cycle
        if (psel && !penable) begin
            d.prdata = rbm_rd(paddr, q);
        end
    end

    // ****************************************************
    // Registers
    // ****************************************************
    // Power-on: initialising, busy low, normal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.st <= rbm_pkg::RBM_INIT;    // see RULE_03
            q.mode <= rbm_pkg::RBM_MODE_NORMAL;
            q.pins <= 2'h0;
            q.addr <= rbm_pkg::ADDR_RST;
            q.rxp <= 1'b0;
            q.cnt <= '0;
            q.hcnt <= '0;
            q.aux <= 1'b0;
            q.prdata <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    // Zero wait states; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = acc && !rbm_mapped(paddr);
    assign prdata = q.prdata;
    assign tx_ready = (q.cnt != rbm_pkg::TXCNT_FULL);
    assign tx_avail = (q.cnt != '0);
    // Host may start using the module at the rising edge
    assign aux = q.aux;    // see RULE_05
    assign mode_out = q.mode;
    // Address of all ones: send to all, accept from all
    assign tx_broadcast = (q.addr == rbm_pkg::ADDR_ALL_ONES);    // see RULE_01
    assign pkt_accept = pkt_valid && radio_en &&
                        ((q.addr == rbm_pkg::ADDR_ALL_ONES) ||
                         (pkt_dst == q.addr));    // see RULE_02
    // Mode decode; radio and serial stay off until running
    assign uart_en = (q.st == rbm_pkg::RBM_RUN);
    assign radio_en = uart_en &&
                      ((q.mode == rbm_pkg::RBM_MODE_NORMAL) ||
                       (q.mode == rbm_pkg::RBM_MODE_WOR));    // see RULE_17
    assign wor_en = uart_en &&
                    (q.mode == rbm_pkg::RBM_MODE_WOR);    // see RULE_18
    assign reg_access_en = uart_en &&    // see RULE_19
                           (q.mode == rbm_pkg::RBM_MODE_CONFIG);
    assign sleep_en = (q.st == rbm_pkg::RBM_SLEEP);

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking rbm_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    init_busy_low_a: assert property (    // see RULE_03
        q.st == rbm_pkg::RBM_INIT |=> !aux)
        else $error("busy high during initialisation");
    txbuf_busy_a: assert property (    // see RULE_09
        q.cnt != '0 |=> !aux)
        else $error("busy high with buffer not empty");
    rx_out_busy_a: assert property (    // see RULE_07
        rx_out_active |=> !aux)
        else $error("busy high during serial output");
    idle_high_a: assert property (    // see RULE_12
        (q.st != rbm_pkg::RBM_INIT && q.cnt == '0 && !q.rxp &&
         !rx_out_active) |=> aux)
        else $error("busy low with no condition");
    no_sample_a: assert property (    // see RULE_13
        (!q.aux && q.st != rbm_pkg::RBM_INIT) |=> $stable(q.pins))
        else $error("pins sampled while busy");
    settle_time_a: assert property (    // see RULE_14
        ($changed(q.mode) && $past(q.st) == rbm_pkg::RBM_RUN &&
         q.mode != rbm_pkg::RBM_MODE_SLEEP) |->
        $past(q.hcnt) >= SETTLE_CYCLES)
        else $error("mode changed before settle time");
    sleep_entry_a: assert property (    // see RULE_22
        (q.st == rbm_pkg::RBM_RUN && q.pins == rbm_pkg::RBM_MODE_SLEEP &&
         q.aux && !busy && q.hcnt >= SLEEP_CYCLES) |=>
        q.st == rbm_pkg::RBM_SLEEP)
        else $error("sleep not entered when due");
    wake_reload_a: assert property (    // see RULE_16
        (q.st == rbm_pkg::RBM_SLEEP && q.aux &&
         q.pins != rbm_pkg::RBM_MODE_SLEEP) |=> ##1 !aux)
        else $error("wake did not hold busy low");
    init_origin_a: assert property (    // see RULE_11
        $rose(q.st == rbm_pkg::RBM_INIT) |->
        $past(q.st) == rbm_pkg::RBM_SLEEP)
        else $error("reconfiguration outside reset or wake");
    buf_cap_a: assert property (    // see RULE_08
        (q.cnt == rbm_pkg::TXCNT_FULL && tx_push && !tx_pop) |=>
        q.cnt == rbm_pkg::TXCNT_FULL)
        else $error("buffer overflowed");
    monitor_accept_a: assert property (    // see RULE_02
        (pkt_valid && radio_en && tx_broadcast) |-> pkt_accept)
        else $error("monitor missed a packet");
    // While idle the sample register tracks the synchronised pins
    pin_follow_a: assert property (    // see RULE_13
        q.aux |=> q.pins == $past(pins_s))
        else $error("pins not followed while idle");
    // Fill count against the handshake outputs the host sees
    buf_step_a: assert property (    // see RULE_08
        (tx_push && tx_ready && !tx_pop) |=> q.cnt == $past(q.cnt) + 10'h001)
        else $error("accepted byte not counted");
    buf_drain_a: assert property (    // see RULE_09
        (tx_pop && tx_avail && !tx_push) |=> q.cnt == $past(q.cnt) - 10'h001)
        else $error("drained byte not counted");
    // Mode machine: a due change lands on the next edge
    quick_change_a: assert property (    // see RULE_15
        (q.st == rbm_pkg::RBM_RUN && q.pins != q.mode && change_ok) |=>
        q.mode == $past(q.pins))
        else $error("idle mode change not applied");
    init_exit_a: assert property (    // see RULE_04
        (q.st == rbm_pkg::RBM_INIT && wr && paddr == rbm_pkg::OFF_CTRL &&
         pwdata[rbm_pkg::CTRL_CFG_DONE]) |=>
        (q.st != rbm_pkg::RBM_INIT && q.mode == $past(pins_s)))
        else $error("initialisation did not end");
    sleep_decode_a: assert property (    // see RULE_20
        sleep_en |-> (!uart_en && !radio_en &&
                      q.mode == rbm_pkg::RBM_MODE_SLEEP))
        else $error("sleep with serial or radio on");

    mode_change_c: cover property (
        $changed(q.mode) && q.st == rbm_pkg::RBM_RUN);
    wake_c: cover property (
        q.st == rbm_pkg::RBM_SLEEP ##1 q.st == rbm_pkg::RBM_INIT);
    buf_full_c: cover property (q.cnt == rbm_pkg::TXCNT_FULL);
    sleep_entry_c: cover property (
        q.st == rbm_pkg::RBM_RUN ##1 q.st == rbm_pkg::RBM_SLEEP);
endmodule

// File: test/rbm_host_model.sv
`timescale 1ns/10ps
// ****************************************************
// Host model: drives the two mode pins
// ****************************************************
module rbm_host_model #(
    parameter int IDLE_CYCLES = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic aux,
    input wire logic [1:0] want_mode,
    input wire logic patient,
    output logic mode_select_low,
    output logic mode_select_high,
    output logic up_seen
);
    int idle_cnt; // Cycles that busy has stood idle
    // Pins move after the idle wait, or at once when told to hurry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= 0;
            up_seen <= 1'b0;
            {mode_select_high, mode_select_low} <= 2'h0;
        end else begin
            idle_cnt <= aux ? idle_cnt + 1 : 0;
            // Usable only from the first idle level after reset
            if (aux) begin
                up_seen <= 1'b1;
            end
            if (up_seen && (!patient || idle_cnt >= IDLE_CYCLES)) begin
                mode_select_high <= want_mode[1];
                mode_select_low <= want_mode[0];
            end
        end
    end
endmodule

// File: test/radio_module_busy_and_mode_control_tb_top.sv
`timescale 1ns/10ps
// ****************************************************
// Bench for the busy indicator and mode control
// ****************************************************
module radio_module_busy_and_mode_control_tb_top;
    localparam int SET = 40; // Shortened idle wait
    localparam int SLP = 20; // Shortened sleep wait
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic mode_select_low, mode_select_high, tx_push, tx_ready, tx_pop;
    logic tx_avail, rx_out_active, pkt_valid, pkt_accept, tx_broadcast;
    logic aux, radio_en, uart_en, reg_access_en, wor_en, sleep_en;
    logic patient, up, pp;
    logic [15:0] pkt_dst;
    logic [1:0] mode_out, want, m;
    logic [32:0] exp_q[$]; // Notes of {error, read data}
    logic [31:0] seed = 32'h5ca9;
    int num_errors = 0;
    int checks_done = 0;
    int cnt; // Bench copy of the buffer fill
    rbm_core #(.SETTLE_CYCLES(SET), .SLEEP_CYCLES(SLP)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mode_select_low, .mode_select_high,
        .tx_push, .tx_ready, .tx_pop, .tx_avail, .rx_out_active,
        .pkt_valid, .pkt_dst, .pkt_accept, .tx_broadcast, .aux,
        .mode_out, .radio_en, .uart_en, .reg_access_en, .wor_en,
        .sleep_en);
    rbm_host_model #(.IDLE_CYCLES(SET)) u_host (.pclk, .presetn, .aux,
        .want_mode(want), .patient, .mode_select_low, .mode_select_high,
        .up_seen(up));
    // Free running clock
    always #2.5 pclk = ~pclk;
    // Xorshift source for stimulus
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // Compare of a port level or count
    task chk_pin(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Compare of a bus answer
    task chk_bus(input logic [31:0] g, input logic [31:0] e);
        chk_pin(g, e);
    endtask
    // End of run, from the main sequence or the watchdog
    task print_verdict;
        $display("Checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; held until pready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              input logic e);
        @(posedge pclk);
        exp_q.push_back({e, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Hold push or pop high for n edges
    task pulse(input logic p, input int n);
        @(posedge pclk);
        if (p) tx_push <= 1'b1;
        else tx_pop <= 1'b1;
        repeat (n) @(posedge pclk);
        tx_push <= 1'b0;
        tx_pop <= 1'b0;
    endtask
    // Bounded waits, sampled on the falling edge where values settle
    task wait_aux(input logic v, input int n);
        @(negedge pclk);
        for (int i = 0; i < n && aux !== v; i++) @(negedge pclk);
        chk_pin(aux, v);
    endtask
    task wait_mode(input logic [1:0] v, input int n);
        @(negedge pclk);
        for (int i = 0; i < n && mode_out !== v; i++) @(negedge pclk);
        chk_pin(mode_out, v);
    endtask
    // Scoreboard: oldest note against each completed transfer
    always @(posedge pclk) begin
        logic [32:0] e;
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            chk_bus(pslverr, e[32]);
            if (!pwrite && !e[32]) chk_bus(prdata, e[31:0]);
        end
    end
    // Watchdog; the run needs well under this many cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        print_verdict;
    end
    // Main sequence
    initial begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, tx_push, tx_pop, rx_out_active} = '0;
        {pkt_valid, paddr, pwdata, pkt_dst, want, patient} = 60'h1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Initialisation keeps busy low until software ends it
        wait_aux(0, 1);
        xfer(0, rbm_pkg::OFF_STAT, 32'h40, 0);
        xfer(0, rbm_pkg::OFF_ADDR, 32'h0, 0);
        xfer(0, 8'h10, 32'h0, 1);
        xfer(1, rbm_pkg::OFF_STAT, 32'hffffffff, 0);
        xfer(0, rbm_pkg::OFF_TXCNT, 32'h0, 0);
        wait_aux(0, 1);
        xfer(1, rbm_pkg::OFF_CTRL, 32'h1, 0);
        wait_aux(1, 4);
        chk_pin(uart_en, 1);
        // Modes 1, 2 and 0 (not sleep), with the host keeping its idle wait
        for (int k = 1; k < 4; k++) begin
            m = 2'(k % 3);
            @(posedge pclk);
            want <= m;
            wait_mode(m, 2 * SET + 20);
            chk_pin({reg_access_en, wor_en, radio_en},
                    {m == 2, m == 1, m != 2});
            xfer(0, rbm_pkg::OFF_STAT, {27'h0, m, m, 1'b1}, 0);
        end
        // All-ones address broadcasts and hears everything
        xfer(1, rbm_pkg::OFF_ADDR, 32'hffff, 0);
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            if (k == 3) xfer(1, rbm_pkg::OFF_ADDR, 32'h1234, 0);
            @(posedge pclk);
            pkt_valid <= 1'b1;
            pkt_dst <= (k == 5) ? 16'h1234 : seed[15:0];
            @(negedge pclk);
            chk_pin(pkt_accept, k < 3 || pkt_dst == 16'h1234);
            chk_pin(tx_broadcast, k < 3);
        end
        // Bytes held keep busy low; pin changes wait for idle
        pulse(1, 3);
        @(posedge pclk);
        pkt_valid <= 1'b0;
        patient <= 1'b0;
        want <= 2'h1;
        xfer(0, rbm_pkg::OFF_TXCNT, 32'h3, 0);
        repeat (20) @(negedge pclk);
        chk_pin(aux, 0);
        chk_pin(mode_out, 0);
        pulse(0, 3);
        wait_aux(1, 4);
        repeat (SET - 5) @(negedge pclk);
        chk_pin(mode_out, 0);
        wait_mode(1, 20);
        // Serial output and the pending flag each hold busy low
        @(posedge pclk);
        rx_out_active <= 1'b1;
        wait_aux(0, 4);
        @(posedge pclk);
        rx_out_active <= 1'b0;
        xfer(1, rbm_pkg::OFF_CTRL, 32'h2, 0);
        wait_aux(0, 4);
        xfer(0, rbm_pkg::OFF_CTRL, 32'h2, 0);
        xfer(1, rbm_pkg::OFF_CTRL, 32'h0, 0);
        wait_aux(1, 4);
        // Fill past full, then drain past empty
        pulse(1, 1001);
        @(negedge pclk);
        chk_pin(tx_ready, 0);
        xfer(0, rbm_pkg::OFF_TXCNT, 32'h3e8, 0);
        pulse(0, 1001);
        @(negedge pclk);
        chk_pin(tx_avail, 0);
        // Random traffic; pops only where the bench count allows
        cnt = 0;
        for (int k = 0; k < 200; k++) begin
            seed = xs(seed);
            pp = seed[1] && cnt > 0;
            @(posedge pclk);
            tx_push <= seed[0];
            tx_pop <= pp;
            cnt = cnt + seed[0] - pp;
        end
        @(posedge pclk);
        {tx_push, tx_pop} <= 2'h0;
        xfer(0, rbm_pkg::OFF_TXCNT, 32'(cnt), 0);
        pulse(0, cnt + 1);
        // Sleep asked while busy follows once the data is gone
        pulse(1, 2);
        @(posedge pclk);
        want <= 2'h3;
        repeat (10) @(negedge pclk);
        chk_pin(sleep_en, 0);
        pulse(0, 2);
        wait_mode(3, SLP + 20);
        chk_pin({sleep_en, uart_en, radio_en}, 3'h4);
        // Waking reloads parameters with busy low
        @(posedge pclk);
        want <= 2'h0;
        wait_aux(0, 10);
        repeat (20) @(negedge pclk);
        chk_pin(aux, 0);
        xfer(1, rbm_pkg::OFF_CTRL, 32'h1, 0);
        wait_aux(1, 4);
        chk_pin(mode_out, 0);
        // Reset in mid-run returns to initialisation
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk_pin({aux, mode_out}, 0);
        @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, rbm_pkg::OFF_STAT, 32'h40, 0);
        repeat (2) @(posedge pclk);
        print_verdict;
    end
endmodule
